// File: logic/nsof_top.sv
`timescale 1ns/1ns
// ==========================================================
// nsof_top
// How it works
// - program fail, bad address, protected: fail flag
// - program command or reset clears program fail
// - erase fail or locked region: erase fail flag
// - erase command or reset clears erase fail
// - write enable/disable commands steer latch
// - busy while array op or reset runs
// - status byte read at feature C0
// - drive register read/written at feature D0
// - drive field decodes to percent, reset-stable
// - protect status powers up one, reset-stable
// - corrected errors: code 01, count less one in extension
// - none 00, uncorrectable 10, 11 unused
// - otp rows 0 to 4 programmed in sequence, row 4 again once reached
// - otp enable redirects array commands to otp
// - enable+lock+write latch+program burns lock
// - locked otp rejects programming, allows reads
// - otp is never erased
// - otp program carries ecc when enabled
// - lock bit starts from stored value, blank zero
// - array rows pass to engine unchanged
// - ecc fields cleared on reset/read start
// - status features C0 and F0 are read-only
module nsof_top
   import nsof_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // serial link
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // array engine
   output nsof_arr_req_t arr_req,
   input wire nsof_arr_rsp_t arr_rsp,
   input wire logic block_protected,
   // otp lock storage
   input wire logic otp_lock_nv,
   output logic otp_lock_burn,
   // pad drive
   output logic [1:0] drive_strength_sel,
   output logic [6:0] drive_percent
);
   // ======================================================
   // link sampling
   logic [2:0] pin_lvl;
   logic sclk_d;
   logic cs_d;
   logic [7:0] rx_byte;
   logic rx_valid;
   logic tx_load;
   logic [7:0] tx_data;

   nsof_sync3 #(.W(3), .RST_VAL(PIN_RST)) u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .din({spi_sclk, spi_cs_n, spi_mosi}),
      .dout(pin_lvl)
   );

   wire frame = ~pin_lvl[1];
   wire sclk_rise = frame & pin_lvl[2] & ~sclk_d;
   wire sclk_fall = frame & ~pin_lvl[2] & sclk_d;
   wire cs_rise = pin_lvl[1] & ~cs_d;

   nsof_spi_byte u_byte (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .frame(frame),
      .sclk_rise(sclk_rise),
      .sclk_fall(sclk_fall),
      .mosi(pin_lvl[0]),
      .load(tx_load),
      .load_data(tx_data),
      .rx_byte(rx_byte),
      .rx_valid(rx_valid),
      .miso(spi_miso)
   );

   assign spi_miso_oe = frame;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sclk_d <= pin_lvl[2];
         cs_d <= pin_lvl[1];
      end
   end

   // ======================================================
   // state
   nsof_state_t st;
   logic [7:0] opcode;
   logic [7:0] faddr;
   logic [23:0] row;
   logic [1:0] addr_cnt;
   logic armed;
   logic write_enable_latch, pfail, efail, block_protect_status, busy, busy_otp, nv_taken;
   logic [1:0] ecc_main;
   logic [1:0] ecc_ext;
   nsof_kind_t busy_kind;
   logic [7:0] rst_cnt;
   logic otp_en, lock_req, otp_lock, ecc_en;
   logic [2:0] otp_next;

   // ======================================================
   // command decode
   wire op_byte = rx_valid & (st == S_OP);
   wire is_wren = op_byte & (rx_byte == CMD_WR_ENABLE);
   wire is_wrdi = op_byte & (rx_byte == CMD_WR_DISABLE);
   wire is_reset = op_byte & (rx_byte == CMD_SOFT_RESET);
   wire rx_feat = (rx_byte == CMD_GET_FEAT) | (rx_byte == CMD_SET_FEAT);
   wire rx_arr = (rx_byte == CMD_PROG_EXEC) | (rx_byte == CMD_BLK_ERASE) |
                 (rx_byte == CMD_PAGE_READ);
   wire op_feat = (opcode == CMD_GET_FEAT) | (opcode == CMD_SET_FEAT);
   wire op_get = opcode == CMD_GET_FEAT;
   wire addr_byte = rx_valid & (st == S_ADDR);
   wire feat_wr = rx_valid & (st == S_DATA) & (opcode == CMD_SET_FEAT);
   wire operation_in_progress = busy | (rst_cnt != 8'h00);
   wire launch = cs_rise & armed & ~operation_in_progress;
   wire go_prog = launch & (opcode == CMD_PROG_EXEC);
   wire go_erase = launch & (opcode == CMD_BLK_ERASE);
   wire go_read = launch & (opcode == CMD_PAGE_READ);
   wire otp_burn_ok = go_prog & write_enable_latch & otp_en & lock_req & ~otp_lock;
   wire otp_row_bad = otp_lock | (row != 24'(otp_next));
   wire prog_reject = go_prog & write_enable_latch & ~otp_burn_ok &
                      (otp_en ? otp_row_bad : block_protected);
   wire prog_start = go_prog & write_enable_latch & ~otp_burn_ok & ~prog_reject;
   wire erase_reject = go_erase & write_enable_latch & (otp_en | block_protected);
   wire erase_start = go_erase & write_enable_latch & ~erase_reject;
   wire op_start = prog_start | erase_start | go_read;
   wire done = arr_rsp.done & busy;

   // ======================================================
   // ecc result decode
   wire ecc_uncorr = arr_rsp.ecc_bits > ECC_MAX_BITS;
   wire ecc_corr = (arr_rsp.ecc_bits != 3'h0) & ~ecc_uncorr;
   wire [1:0] next_ecc_main = ecc_uncorr ? ECC_UNCORR : (ecc_corr ? ECC_CORR : ECC_NONE);
   wire [1:0] next_ecc_ext = ecc_corr ? 2'(arr_rsp.ecc_bits - 3'h1) : 2'h0;

   // ======================================================
   // feature read mux
   wire [7:0] rd_status = {2'h0, ecc_main, pfail, efail, write_enable_latch, operation_in_progress};
   wire [7:0] rd_status2 = {2'h0, ecc_ext, block_protect_status, 3'h0};
   wire [7:0] rd_feature = {otp_lock | lock_req, otp_en, 1'b0, ecc_en, 4'h0};
   wire [7:0] rd_drive = {1'b0, drive_strength_sel, 5'h00};
   wire [7:0] rd_addr = (st == S_ADDR) ? rx_byte : faddr;
   assign tx_data = (rd_addr == FADDR_STATUS) ? rd_status :
                    (rd_addr == FADDR_STATUS2) ? rd_status2 :
                    (rd_addr == FADDR_FEATURE) ? rd_feature :
                    (rd_addr == FADDR_DRIVE) ? rd_drive : 8'h00;
   assign tx_load = rx_valid & op_get & ((st == S_ADDR) | (st == S_DATA));

   // ======================================================
   // command sequencer
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= S_OP;
      end else if (!frame) begin
         st <= S_OP;
      end else if (rx_valid) begin
         case (st)
            S_OP: st <= (rx_feat | rx_arr) ? S_ADDR : S_SKIP;
            S_ADDR: st <= op_feat ? S_DATA : ((addr_cnt == ADDR_LAST) ? S_SKIP : S_ADDR);
            S_DATA: st <= op_get ? S_DATA : S_SKIP;
            S_SKIP: st <= S_SKIP;
            default: st <= S_OP;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         opcode <= 8'h00;
         faddr <= 8'h00;
         row <= 24'h000000;
         addr_cnt <= 2'h0;
         armed <= 1'b0;
      end else begin
         if (op_byte) begin
            opcode <= rx_byte;
            addr_cnt <= 2'h0;
         end else if (addr_byte) begin
            faddr <= rx_byte;
            row <= {row[15:0], rx_byte};
            addr_cnt <= addr_cnt + 2'h1;
         end
         if (op_byte || cs_rise) begin
            armed <= 1'b0;
         end else if (addr_byte && !op_feat && addr_cnt == ADDR_LAST) begin
            armed <= 1'b1;
         end
      end
   end

   // ======================================================
   // status flags
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         write_enable_latch <= 1'b0;
         pfail <= 1'b0;
         efail <= 1'b0;
      end else begin
         if (is_wren) begin
            write_enable_latch <= 1'b1;
         end else if (is_wrdi || is_reset || otp_burn_ok || (done && busy_kind != ARR_READ)) begin
            write_enable_latch <= 1'b0;
         end
         if (done && busy_kind == ARR_PROG) begin
            pfail <= arr_rsp.fail;
         end else if (prog_reject) begin
            pfail <= 1'b1;
         end else if (go_prog || is_reset) begin
            pfail <= 1'b0;
         end
         if (done && busy_kind == ARR_ERASE) begin
            efail <= arr_rsp.fail;
         end else if (erase_reject) begin
            efail <= 1'b1;
         end else if (go_erase || is_reset) begin
            efail <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ecc_main <= ECC_NONE;
         ecc_ext <= 2'h0;
         block_protect_status <= BPS_RST;
      end else begin
         if (done && busy_kind == ARR_READ && ecc_en) begin
            ecc_main <= next_ecc_main;
            ecc_ext <= next_ecc_ext;
         end else if (go_read || is_reset) begin
            ecc_main <= ECC_NONE;
            ecc_ext <= 2'h0;
         end
         if (launch && !otp_en) begin
            block_protect_status <= block_protected;
         end
      end
   end

   // ======================================================
   // busy tracking
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         busy_kind <= ARR_READ;
         busy_otp <= 1'b0;
         rst_cnt <= 8'h00;
      end else begin
         if (op_start) begin
            busy <= 1'b1;
            busy_kind <= prog_start ? ARR_PROG : (erase_start ? ARR_ERASE : ARR_READ);
            busy_otp <= otp_en;
         end else if (done) begin
            busy <= 1'b0;
         end
         if (is_reset) begin
            rst_cnt <= RESET_BUSY_CYCLES;
         end else if (rst_cnt != 8'h00) begin
            rst_cnt <= rst_cnt - 8'h01;
         end
      end
   end

   // ======================================================
   // feature settings and otp lock
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         drive_strength_sel <= DRIVE_RST;
         otp_en <= 1'b0;
         lock_req <= 1'b0;
         ecc_en <= ECC_EN_RST;
      end else if (feat_wr && faddr == FADDR_DRIVE) begin
         drive_strength_sel <= rx_byte[DRIVE_LO_BIT+:2];
      end else if (feat_wr && faddr == FADDR_FEATURE) begin
         otp_en <= rx_byte[FEAT_OTP_EN_BIT];
         lock_req <= rx_byte[FEAT_LOCK_BIT];
         ecc_en <= rx_byte[FEAT_ECC_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         otp_lock <= OTP_LOCK_RST;
         nv_taken <= 1'b0;
         otp_lock_burn <= 1'b0;
         otp_next <= 3'h0;
      end else begin
         nv_taken <= 1'b1;
         otp_lock_burn <= otp_burn_ok;
         if (!nv_taken) begin
            otp_lock <= otp_lock_nv;
         end else if (otp_burn_ok) begin
            otp_lock <= 1'b1;
         end
         if (done && busy_kind == ARR_PROG && busy_otp && !arr_rsp.fail &&
             otp_next != OTP_PAGES) begin
            otp_next <= otp_next + 3'h1;
         end
      end
   end

   // ======================================================
   // engine request and pad drive
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         arr_req <= '0;
         drive_percent <= DRIVE_PCT_0;
      end else begin
         arr_req.start <= op_start;
         if (op_start) begin
            arr_req.kind <= prog_start ? ARR_PROG : (erase_start ? ARR_ERASE : ARR_READ);
            arr_req.otp <= otp_en;
            arr_req.ecc <= ecc_en;
            arr_req.row <= row;
         end
         case (drive_strength_sel)
            2'h0: drive_percent <= DRIVE_PCT_0;
            2'h1: drive_percent <= DRIVE_PCT_1;
            2'h2: drive_percent <= DRIVE_PCT_2;
            2'h3: drive_percent <= DRIVE_PCT_3;
            default: drive_percent <= DRIVE_PCT_0;
         endcase
      end
   end

   // ======================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   property p_wren; is_wren |=> write_enable_latch && rd_status[1]; endproperty
   a_wren: assert property (p_wren) else $error("write latch not set");
   property p_prog_rej; prog_reject |=> pfail && !busy; endproperty
   a_prog_rej: assert property (p_prog_rej) else $error("program reject");
   property p_prog_clr; prog_start |=> !pfail && busy; endproperty
   a_prog_clr: assert property (p_prog_clr) else $error("program fail not cleared");
   property p_erase_otp; go_erase && write_enable_latch && otp_en |=> efail && !arr_req.start; endproperty
   a_erase_otp: assert property (p_erase_otp) else $error("otp erase started");
   property p_read_clr; go_read |=> ecc_main == ECC_NONE && ecc_ext == 2'h0 && operation_in_progress; endproperty
   a_read_clr: assert property (p_read_clr) else $error("ecc not cleared");
   property p_uncorr; done && busy_kind == ARR_READ && ecc_en && ecc_uncorr |=>
      ecc_main == ECC_UNCORR; endproperty
   a_uncorr: assert property (p_uncorr) else $error("ecc uncorrectable code");
   property p_corr; done && busy_kind == ARR_READ && ecc_en && ecc_corr |=>
      ecc_main == ECC_CORR && ecc_ext == $past(arr_rsp.ecc_bits[1:0]) - 2'h1; endproperty
   a_corr: assert property (p_corr) else $error("ecc corrected code");
   property p_lock_keep; nv_taken && otp_lock |=> otp_lock; endproperty
   a_lock_keep: assert property (p_lock_keep) else $error("otp lock dropped");
   property p_reset_busy; is_reset |=> operation_in_progress [*8]; endproperty
   a_reset_busy: assert property (p_reset_busy) else $error("reset busy short");
   property p_drive_wr; feat_wr && faddr == FADDR_DRIVE |=>
      drive_strength_sel == $past(rx_byte[6:5]) ##1 rd_drive[6:5] == drive_strength_sel;
   endproperty
   a_drive_wr: assert property (p_drive_wr) else $error("drive write lost");
endmodule : nsof_top

// File: include/nsof_pkg.sv
// ==========================================================
// nsof_pkg
package nsof_pkg;
   // ======================================================
   // serial commands
   localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
   localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
   localparam logic [7:0] CMD_GET_FEAT = 8'h0F;
   localparam logic [7:0] CMD_SET_FEAT = 8'h1F;
   localparam logic [7:0] CMD_PROG_EXEC = 8'h10;
   localparam logic [7:0] CMD_BLK_ERASE = 8'hD8;
   localparam logic [7:0] CMD_PAGE_READ = 8'h13;
   localparam logic [7:0] CMD_SOFT_RESET = 8'hFF;
   // ======================================================
   // feature addresses
   localparam logic [7:0] FADDR_FEATURE = 8'hB0;
   localparam logic [7:0] FADDR_STATUS = 8'hC0;
   localparam logic [7:0] FADDR_DRIVE = 8'hD0;
   localparam logic [7:0] FADDR_STATUS2 = 8'hF0;
   // ======================================================
   // field positions
   localparam int FEAT_LOCK_BIT = 7;
   localparam int FEAT_OTP_EN_BIT = 6;
   localparam int FEAT_ECC_EN_BIT = 4;
   localparam int DRIVE_LO_BIT = 5;
   // ======================================================
   // reset values
   localparam logic [1:0] DRIVE_RST = 2'h0;
   localparam logic ECC_EN_RST = 1'b1;
   localparam logic BPS_RST = 1'b1;
   localparam logic OTP_LOCK_RST = 1'b0;
   localparam logic [2:0] PIN_RST = 3'h2;
   // ======================================================
   // ecc result codes
   localparam logic [1:0] ECC_NONE = 2'h0;
   localparam logic [1:0] ECC_CORR = 2'h1;
   localparam logic [1:0] ECC_UNCORR = 2'h2;
   localparam logic [2:0] ECC_MAX_BITS = 3'h4;
   // ======================================================
   // drive strength in percent
   localparam logic [6:0] DRIVE_PCT_0 = 7'h64;
   localparam logic [6:0] DRIVE_PCT_1 = 7'h4B;
   localparam logic [6:0] DRIVE_PCT_2 = 7'h32;
   localparam logic [6:0] DRIVE_PCT_3 = 7'h19;
   // ======================================================
   // counts and timing
   localparam logic [2:0] OTP_PAGES = 3'h4;
   localparam logic [1:0] ADDR_LAST = 2'h2;
   localparam int CLK_NS = 100;
   localparam int RESET_BUSY_NS = 1000;
   localparam logic [7:0] RESET_BUSY_CYCLES = 8'((RESET_BUSY_NS + CLK_NS - 1) / CLK_NS);
   // ======================================================
   // types
   typedef enum logic [1:0] {ARR_READ = 2'h0, ARR_PROG = 2'h1, ARR_ERASE = 2'h2} nsof_kind_t;
   typedef enum logic [3:0] {
      S_OP = 4'h1,
      S_ADDR = 4'h2,
      S_DATA = 4'h4,
      S_SKIP = 4'h8
   } nsof_state_t;
   typedef struct packed {
      logic start;
      nsof_kind_t kind;
      logic otp;
      logic ecc;
      logic [23:0] row;
   } nsof_arr_req_t;
   typedef struct packed {
      logic done;
      logic fail;
      logic [2:0] ecc_bits;
   } nsof_arr_rsp_t;
endpackage : nsof_pkg

// File: logic/nsof_sync3.sv
`timescale 1ns/1ns
// ==========================================================
// nsof_sync3: three flops, level taken when second and third agree
module nsof_sync3 #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // pins
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   wire [W-1:0] agree = ~(s2 ^ s3);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         dout <= (agree & s3) | (~agree & dout);
      end
   end
endmodule : nsof_sync3

// File: logic/nsof_spi_byte.sv
`timescale 1ns/1ns
// ==========================================================
// nsof_spi_byte: mode 0 byte shifter, msb first
module nsof_spi_byte (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // link events
   input wire logic frame,
   input wire logic sclk_rise,
   input wire logic sclk_fall,
   input wire logic mosi,
   // byte side
   input wire logic load,
   input wire logic [7:0] load_data,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic miso
);
   logic [2:0] cnt;
   logic [6:0] sh;
   logic [7:0] tx;

   assign miso = tx[7];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 3'h0;
         sh <= 7'h00;
         rx_byte <= 8'h00;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= frame & sclk_rise & (cnt == 3'h7);
         if (!frame) begin
            cnt <= 3'h0;
         end else if (sclk_rise) begin
            cnt <= cnt + 3'h1;
            sh <= {sh[5:0], mosi};
            if (cnt == 3'h7) begin
               rx_byte <= {sh, mosi};
            end
         end
      end
   end

   // no shift on the fall that ends a byte, so a freshly loaded msb holds
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx <= 8'h00;
      end else if (!frame) begin
         tx <= 8'h00;
      end else if (load) begin
         tx <= load_data;
      end else if (sclk_fall && cnt != 3'h0) begin
         tx <= {tx[6:0], 1'b0};
      end
   end
endmodule : nsof_spi_byte

// File: tb/nsof_host.sv
`timescale 1ns/1ns
// ==========================================================
// nsof_host: mode 0 serial host, clock runs only inside frames
module nsof_host (
   // clock
   input wire logic clk,
   // link pins
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // one frame, bytes msb first, eight clocks a bit; rx keeps the last byte read
   // miso taken at the end of the high phase, as it follows the fall a few clocks late
   task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx);
      rx = 8'h00;
      @(posedge clk);
      cs_n <= 1'b0;
      foreach (tx[i]) begin
         for (int b = 7; b >= 0; b--) begin
            mosi <= tx[i][b];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            rx = {rx[6:0], miso};
            sclk <= 1'b0;
         end
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      // released line must not keep its last level
      mosi <= ~mosi;
      repeat (8) @(posedge clk);
   endtask : xfer
endmodule : nsof_host

// File: tb/tb_nsof_top.sv
`timescale 1ns/1ns
// ==========================================================
// tb_nsof_top
module tb_nsof_top import nsof_pkg::*;;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic blk_prot = 1'b0;
   logic rsp_fail = 1'b0;
   logic done = 1'b0;
   logic [2:0] rsp_ecc = 3'h0;
   logic sclk, cs_n, mosi, miso, burn, moe;
   logic nv_lock = 1'b0;
   int noe = 0;
   logic [7:0] d;
   logic [1:0] dsel;
   logic [6:0] dpct;
   nsof_arr_req_t req;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   int cnt = 0;
   int nstart = 0;
   int nburn = 0;
   always #50 ref_clk = ~ref_clk;
   nsof_host nsof_host_i (.clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   nsof_top nsof_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .spi_sclk(sclk),
      .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(moe),
      .arr_req(req), .arr_rsp(nsof_arr_rsp_t'({done, rsp_fail, rsp_ecc})),
      .block_protected(blk_prot), .otp_lock_nv(nv_lock), .otp_lock_burn(burn),
      .drive_strength_sel(dsel), .drive_percent(dpct));
   // ==========================================================
   // array engine: done 300 cycles after start; timeout
   always @(posedge ref_clk) begin
      done <= (cnt == 1);
      if (req.start === 1'b1) begin
         cnt <= 300;
         nstart <= nstart + 1;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
      if (burn === 1'b1) begin
         nburn <= nburn + 1;
         nv_lock <= 1'b1;
      end
      if (moe === 1'b1) begin
         noe <= noe + 1;
      end
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_mismatch++;
         summarize();
      end
   end
   // ==========================================================
   // helpers
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] q[$]);
      logic [7:0] r;
      nsof_host_i.xfer(q, r);
   endtask : cmd
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      nsof_host_i.xfer('{CMD_GET_FEAT, a, 8'h00}, d);
      chk($sformatf("feature %h", a), e, d & m);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      cmd('{CMD_SET_FEAT, a, v});
   endtask : wr
   task automatic idle();
      for (int i = 0; i < 20; i++) begin
         nsof_host_i.xfer('{CMD_GET_FEAT, FADDR_STATUS, 8'h00}, d);
         if (d[0] === 1'b0) begin
            return;
         end
      end
      chk("busy", 8'h00, d);
   endtask : idle
   task automatic arr(input logic [7:0] op, input logic [7:0] r, input logic we);
      if (we) begin
         cmd('{CMD_WR_ENABLE});
      end
      cmd('{op, 8'h00, 8'h00, r});
   endtask : arr
   // ==========================================================
   // scenarios
   task automatic s_por();
      rd(FADDR_STATUS, 8'hFF, 8'h00);
      rd(FADDR_STATUS2, 8'hFF, 8'h08);
      rd(FADDR_FEATURE, 8'hFF, 8'h10);
      rd(FADDR_DRIVE, 8'hFF, 8'h00);
      rd(8'h55, 8'hFF, 8'h00);
      chk("percent", 8'h64, {1'b0, dpct});
      chk("oe idle", 8'h00, {7'h00, moe});
      chk("oe in frame", 8'h01, 8'(noe != 0));
   endtask : s_por
   task automatic s_drive();
      logic [6:0] pct[4] = '{7'h64, 7'h4B, 7'h32, 7'h19};
      for (int v = 0; v < 4; v++) begin
         wr(FADDR_DRIVE, 8'(v << 5));
         rd(FADDR_DRIVE, 8'hFF, 8'(v << 5));
         chk("percent", {1'b0, pct[v]}, {1'b0, dpct});
         chk("sel", 8'(v), {6'h00, dsel});
      end
   endtask : s_drive
   task automatic s_wel();
      cmd('{CMD_WR_ENABLE});
      rd(FADDR_STATUS, 8'hFF, 8'h02);
      cmd('{CMD_WR_DISABLE});
      rd(FADDR_STATUS, 8'hFF, 8'h00);
   endtask : s_wel
   task automatic s_prog();
      @(posedge ref_clk);
      rsp_fail <= 1'b1;
      arr(CMD_PROG_EXEC, 8'h05, 1'b1);
      rd(FADDR_STATUS, 8'hFF, 8'h03);
      idle();
      rd(FADDR_STATUS, 8'hFF, 8'h08);
      arr(CMD_PROG_EXEC, 8'h05, 1'b0);
      rd(FADDR_STATUS, 8'hFF, 8'h00);
      @(posedge ref_clk);
      blk_prot <= 1'b1;
      arr(CMD_PROG_EXEC, 8'h05, 1'b1);
      rd(FADDR_STATUS, 8'h09, 8'h08);
      chk("starts", 8'h01, 8'(nstart));
   endtask : s_prog
   task automatic s_erase();
      arr(CMD_BLK_ERASE, 8'h40, 1'b1);
      rd(FADDR_STATUS, 8'h05, 8'h04);
      @(posedge ref_clk);
      blk_prot <= 1'b0;
      rsp_fail <= 1'b0;
      arr(CMD_BLK_ERASE, 8'h40, 1'b1);
      chk("row", 8'h40, req.row[7:0]);
      rd(FADDR_STATUS, 8'h05, 8'h01);
      idle();
      chk("starts", 8'h02, 8'(nstart));
   endtask : s_erase
   task automatic s_ecc();
      logic [2:0] e;
      for (int i = 0; i < 6; i++) begin
         e = 3'(i);
         @(posedge ref_clk);
         rsp_ecc <= e;
         arr(CMD_PAGE_READ, 8'h07, 1'b0);
         rd(FADDR_STATUS, 8'h31, 8'h01);
         idle();
         rd(FADDR_STATUS, 8'h30, e == 0 ? 8'h00 : (e <= 4 ? 8'h10 : 8'h20));
         if (e inside {[1:4]}) begin
            rd(FADDR_STATUS2, 8'h38, {2'b00, 2'(e - 3'h1), 4'h0});
         end
      end
      wr(FADDR_FEATURE, 8'h00);
      arr(CMD_PAGE_READ, 8'h07, 1'b0);
      chk("ecc off", 8'h00, {7'h00, req.ecc});
      idle();
      rd(FADDR_STATUS, 8'h30, 8'h00);
   endtask : s_ecc
   task automatic s_reset();
      wr(FADDR_STATUS, 8'hFF);
      wr(FADDR_STATUS2, 8'h08);
      rd(FADDR_STATUS, 8'hFF, 8'h08);
      rd(FADDR_STATUS2, 8'h08, 8'h00);
      cmd('{CMD_WR_ENABLE});
      cmd('{CMD_SOFT_RESET});
      rd(FADDR_STATUS, 8'hFF, 8'h00);
      rd(FADDR_DRIVE, 8'hFF, 8'h60);
   endtask : s_reset
   task automatic s_otp();
      wr(FADDR_FEATURE, 8'h50);
      arr(CMD_PROG_EXEC, 8'h01, 1'b1);
      rd(FADDR_STATUS, 8'h09, 8'h08);
      arr(CMD_PROG_EXEC, 8'h00, 1'b1);
      idle();
      chk("starts", 8'h0A, 8'(nstart));
      chk("otp ecc", 8'h03, {6'h00, req.otp, req.ecc});
      arr(CMD_BLK_ERASE, 8'h00, 1'b1);
      rd(FADDR_STATUS, 8'h05, 8'h04);
      wr(FADDR_FEATURE, 8'hD0);
      arr(CMD_PROG_EXEC, 8'h01, 1'b1);
      rd(FADDR_FEATURE, 8'h80, 8'h80);
      chk("burns", 8'h01, 8'(nburn));
      wr(FADDR_FEATURE, 8'h50);
      rd(FADDR_FEATURE, 8'h80, 8'h80);
      arr(CMD_PROG_EXEC, 8'h01, 1'b1);
      rd(FADDR_STATUS, 8'h09, 8'h08);
      arr(CMD_PAGE_READ, 8'h00, 1'b0);
      idle();
      chk("starts", 8'h0B, 8'(nstart));
   endtask : s_otp
   task automatic s_relock();
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rd(FADDR_FEATURE, 8'hFF, 8'h90);
      rd(FADDR_STATUS2, 8'h08, 8'h08);
      wr(FADDR_FEATURE, 8'h50);
      arr(CMD_PROG_EXEC, 8'h00, 1'b1);
      rd(FADDR_STATUS, 8'h09, 8'h08);
      chk("starts", 8'h0B, 8'(nstart));
   endtask : s_relock
   task automatic summarize();
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      s_por();
      s_drive();
      s_wel();
      s_prog();
      s_erase();
      s_ecc();
      s_reset();
      s_otp();
      s_relock();
      summarize();
   end
endmodule : tb_nsof_top
